// ==== rtl/roc_pkg.sv ====
/*
  roc_pkg: constants, source codes and lock functions for the relay output conditioner.
  assumes a 10 MHz system clock and a 32-bit apb register bus.
*/
package roc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_W = 14;
  localparam logic [13:0] MS_MAX = 14'h270f;
  localparam logic [13:0] MS_RST = 14'h0000;
  localparam int COND_W = 16;

  // ----------------------------------------
  // source codes
  // ----------------------------------------
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] SRC_NO_FAULT = 4'h1;
  localparam logic [3:0] SRC_BRAKE = 4'h9;
  localparam logic [3:0] SRC_LINE = 4'ha;
  localparam logic [3:0] SRC_OUTPUT = 4'hb;
  localparam logic [3:0] SRC_END_OF_REEL = 4'hc;
  localparam logic [3:0] SRC_WOBBLE_SYNC = 4'hd;
  localparam logic [3:0] SRC_PRECHARGE = 4'he;
  localparam logic [3:0] SRC_MAX = 4'he;
  localparam logic [3:0] SRC_APP_FIRST = 4'h9;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [7:0] ADDR_RELAY3_BASE = 8'h00;
  localparam logic [7:0] ADDR_RELAY4_BASE = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_ON_DELAY = 4'h4;
  localparam logic [3:0] OFS_OFF_HOLD = 4'h8;
  localparam logic [3:0] OFS_APP_SRC = 4'hc;
  localparam int CFG_SRC_LSB = 0;
  localparam int CFG_POL_BIT = 8;
  localparam logic POL_RST = 1'b1;

  function automatic logic roc_app_only(input logic [3:0] src);
    return (src >= SRC_APP_FIRST);
  endfunction : roc_app_only

  function automatic logic roc_delay_locked(input logic [3:0] src);
    return src == SRC_NO_FAULT || src == SRC_BRAKE || src == SRC_PRECHARGE ||
           src == SRC_LINE || src == SRC_OUTPUT;
  endfunction : roc_delay_locked

  function automatic logic roc_hold_locked(input logic [3:0] src);
    return roc_delay_locked(src);
  endfunction : roc_hold_locked

  function automatic logic roc_pol_locked(input logic [3:0] src);
    return src == SRC_NO_FAULT || src == SRC_BRAKE || src == SRC_PRECHARGE || src == SRC_LINE;
  endfunction : roc_pol_locked

  function automatic logic [13:0] roc_clamp_ms(input logic [31:0] v);
    return (v > 32'(MS_MAX)) ? MS_MAX : v[13:0];
  endfunction : roc_clamp_ms
endpackage : roc_pkg

// ==== rtl/roc_chan_if.sv ====
/*
  roc_chan_if: settings and results passed between the top and one relay channel.
  assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
interface roc_chan_if;
  logic en;
  logic tick;
  logic cond;
  logic pol;
  logic [13:0] on_delay;
  logic [13:0] off_hold;
  logic state;
  logic out;
  modport ctl (output en, tick, cond, pol, on_delay, off_hold, input state, out);
  modport chan (input en, tick, cond, pol, on_delay, off_hold, output state, out);
endinterface : roc_chan_if

// ==== rtl/roc_channel.sv ====
/*
  roc_channel: turn-on delay, turn-off hold and polarity for one relay output.
  assumes a one-cycle millisecond tick and settings already restricted by the top.
*/
`timescale 1ns/1ns
module roc_channel
  import roc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  roc_chan_if.chan bus
);
  // ----------------------------------------
  // filter
  // ----------------------------------------
  logic state_reg;
  logic out_reg;
  logic [13:0] cnt_reg;
  wire differs = bus.en & (bus.cond != state_reg);
  wire [13:0] limit = bus.cond ? bus.on_delay : bus.off_hold;
  wire done = differs & ((limit == 14'h0000) | (bus.tick & (cnt_reg >= limit)));
  wire rise_ok = (bus.on_delay == 14'h0000) | (bus.tick & (cnt_reg >= bus.on_delay));
  wire fall_ok = (bus.off_hold == 14'h0000) | (bus.tick & (cnt_reg >= bus.off_hold));

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !bus.en) begin
      state_reg <= 1'b0;
      cnt_reg <= 14'h0000;
    end else if (!differs) begin
      cnt_reg <= 14'h0000;
    end else if (done) begin
      state_reg <= bus.cond;
      cnt_reg <= 14'h0000;
    end else if (bus.tick) begin
      cnt_reg <= cnt_reg + 14'h0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= bus.en & (bus.pol ? state_reg : ~state_reg);
    end
  end

  assign bus.state = state_reg;
  assign bus.out = out_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence rise_seq;
    bus.en && $rose(state_reg);
  endsequence
  sequence fall_seq;
    bus.en && $fell(state_reg);
  endsequence

  rise_after_delay_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    rise_seq |-> $past(rise_ok)) else $error("relay turned on before its delay");
  fall_after_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    fall_seq |-> $past(fall_ok)) else $error("relay turned off before its hold time");
  count_restart_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.en && bus.cond == state_reg) |=> cnt_reg == 14'h0000) else $error("counter not restarted");
  zero_delay_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (bus.en && bus.cond && !state_reg && bus.on_delay == 14'h0000) |=> state_reg)
    else $error("zero delay not immediate");
endmodule : roc_channel

// ==== rtl/roc_relay_output_conditioner.sv ====
/*
  roc_relay_output_conditioner: apb slave and two conditioned relay outputs (relay 3 and 4).
  assumes internal conditions arrive on the system clock and option card presence on pins.
*/
`timescale 1ns/1ns
module roc_relay_output_conditioner
  import roc_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [COND_W-1:0] i_cond,
  input wire logic i_card3_present,
  input wire logic i_card4_present,
  output logic o_relay3_drive,
  output logic o_relay4_drive
);
  // ----------------------------------------
  // millisecond tick
  // ----------------------------------------
  localparam logic [13:0] DIV_LAST = 14'(TICK_CYCLES_P - 1);
  logic [13:0] div_reg;
  wire tick = (div_reg == DIV_LAST);

  always_ff @(posedge i_clk) begin
    if (!i_resetn || tick) begin
      div_reg <= 14'h0000;
    end else begin
      div_reg <= div_reg + 14'h0001;
    end
  end

  // ----------------------------------------
  // option card synchronisers
  // ----------------------------------------
  logic [1:0] card_meta_reg;
  logic [1:0] card_reg;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      card_meta_reg <= 2'h0;
      card_reg <= 2'h0;
    end else begin
      card_meta_reg <= {i_card4_present, i_card3_present};
      card_reg <= card_meta_reg;
    end
  end

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire setup = i_psel & ~i_penable;
  wire access = i_psel & i_penable;
  wire in_chan = (i_paddr[7:5] == 3'h0) & (i_paddr[1:0] == 2'h0);
  wire is_status = (i_paddr == ADDR_STATUS);
  wire addr_ok = in_chan | is_status;
  wire ch_idx = (i_paddr[7:4] == ADDR_RELAY4_BASE[7:4]);
  wire [3:0] ofs = i_paddr[3:0];
  wire wr = access & i_pwrite & in_chan;
  wire [3:0] wsrc = i_pwdata[CFG_SRC_LSB +: 4];

  assign o_pready = access;
  assign o_pslverr = access & ~addr_ok;

  // ----------------------------------------
  // channel settings
  // ----------------------------------------
  logic [1:0][3:0] src_reg;
  logic [1:0] pol_reg;
  logic [1:0][13:0] dly_reg;
  logic [1:0][13:0] hold_reg;
  logic [1:0] drive;
  logic [1:0] state;
  logic [1:0] cond;
  roc_chan_if ch_if[2] ();

  for (genvar g = 0; g < 2; g++) begin : g_ch
    wire wr_ch = wr & (ch_idx == 1'(g)) & card_reg[g];
    wire cfg_wr = wr_ch & (ofs == OFS_CFG);
    wire app_wr = wr_ch & (ofs == OFS_APP_SRC);
    wire cfg_ok = cfg_wr & ~roc_app_only(wsrc) & (wsrc <= SRC_MAX);
    wire app_ok = app_wr & (wsrc <= SRC_MAX);
    wire [3:0] src_next = (cfg_ok | app_ok) ? wsrc : src_reg[g];

    always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
        src_reg[g] <= SRC_NONE;
        pol_reg[g] <= POL_RST;
        dly_reg[g] <= MS_RST;
        hold_reg[g] <= MS_RST;
      end else begin
        src_reg[g] <= src_next;
        if (roc_pol_locked(src_next)) begin
          pol_reg[g] <= POL_RST;
        end else if (cfg_wr) begin
          pol_reg[g] <= i_pwdata[CFG_POL_BIT];
        end
        if (roc_delay_locked(src_next)) begin
          dly_reg[g] <= MS_RST;
        end else if (wr_ch && ofs == OFS_ON_DELAY) begin
          dly_reg[g] <= roc_clamp_ms(i_pwdata);
        end
        if (roc_hold_locked(src_next)) begin
          hold_reg[g] <= MS_RST;
        end else if (wr_ch && ofs == OFS_OFF_HOLD) begin
          hold_reg[g] <= roc_clamp_ms(i_pwdata);
        end
      end
    end

    assign cond[g] = (src_reg[g] == SRC_NONE) ? 1'b0 : i_cond[src_reg[g]];
    assign ch_if[g].en = card_reg[g];
    assign ch_if[g].tick = tick;
    assign ch_if[g].cond = cond[g];
    assign ch_if[g].pol = pol_reg[g];
    assign ch_if[g].on_delay = dly_reg[g];
    assign ch_if[g].off_hold = hold_reg[g];
    assign state[g] = ch_if[g].state;
    assign drive[g] = ch_if[g].out;

    roc_channel u_chan (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .bus(ch_if[g])
    );

    delay_lock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      roc_delay_locked(src_reg[g]) |-> dly_reg[g] == 14'h0000) else $error("delay not held at zero");
    hold_lock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      roc_hold_locked(src_reg[g]) |-> hold_reg[g] == 14'h0000) else $error("hold not held at zero");
    pol_lock_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      roc_pol_locked(src_reg[g]) |-> pol_reg[g]) else $error("polarity not locked positive");
    app_src_guard_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (cfg_wr && roc_app_only(wsrc)) |=> $stable(src_reg[g])) else $error("app source taken by plain config");
    absent_off_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !card_reg[g] ##1 !card_reg[g] |-> !drive[g]) else $error("absent channel drives relay");
    neg_logic_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      (card_reg[g] && !pol_reg[g] && state[g]) |=> !drive[g]) else $error("negative logic output wrong");
    default_src_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !$past(i_resetn) |-> src_reg[g] == SRC_NONE && pol_reg[g]) else $error("bad default after reset");
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  wire [31:0] status_word = {24'h000000, drive[1], state[1], cond[1], drive[0], state[0], cond[0], card_reg};
  wire [31:0] cfg_word = {23'h000000, pol_reg[ch_idx], 4'h0, src_reg[ch_idx]};
  wire [31:0] chan_word = (ofs == OFS_CFG) ? cfg_word :
                          (ofs == OFS_ON_DELAY) ? {18'h00000, dly_reg[ch_idx]} :
                          (ofs == OFS_OFF_HOLD) ? {18'h00000, hold_reg[ch_idx]} :
                          {28'h0000000, src_reg[ch_idx]};
  wire [31:0] rd_word = is_status ? status_word :
                        (in_chan & card_reg[ch_idx]) ? chan_word : 32'h00000000;
  logic [31:0] prdata_reg;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      prdata_reg <= 32'h00000000;
    end else if (setup) begin
      prdata_reg <= rd_word;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_relay3_drive = drive[0];
  assign o_relay4_drive = drive[1];
endmodule : roc_relay_output_conditioner

// ==== bench/roc_relay_model.sv ====
/*
  roc_relay_model: relay driver stage switching an external contactor.
  assumes the drive level arrives on the system clock.
*/
`timescale 1ns/1ns
module roc_relay_model (
  input wire logic i_clk,
  input wire logic i_drive,
  output logic o_closed,
  output int o_switches
);
  initial begin
    o_closed = 1'b0;
    o_switches = 0;
  end
  // contact follows drive one clock later; each change counted
  always @(posedge i_clk) begin
    if (i_drive !== o_closed) o_switches <= o_switches + 1;
    o_closed <= i_drive;
  end
endmodule : roc_relay_model

// ==== bench/tb_top.sv ====
/*
  tb_top: self-checking bench for the relay output conditioner.
  assumes a 10-cycle millisecond tick and zero-wait apb answers.
*/
`timescale 1ns/1ns
module tb_top
  import roc_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, card3, card4, drv3, drv4, cl3, cl4, slverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [COND_W-1:0] cond;
  int sw3, sw4, err_count, n_tests;

  roc_relay_output_conditioner #(.TICK_CYCLES_P(10)) u_dut (.i_clk(clk), .i_resetn(resetn),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_cond(cond),
    .i_card3_present(card3), .i_card4_present(card4), .o_relay3_drive(drv3), .o_relay4_drive(drv4));
  roc_relay_model u_relay3 (.i_clk(clk), .i_drive(drv3), .o_closed(cl3), .o_switches(sw3));
  roc_relay_model u_relay4 (.i_clk(clk), .i_drive(drv4), .o_closed(cl4), .o_switches(sw4));

  always #50 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'(pready));
      conclude;
    end
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : acc

  task automatic wait_drv(input logic v, input int n);
    int i;
    for (i = 0; i < n && drv3 !== v; i++) @(posedge clk);
    chk("relay3 drive", 32'(v), 32'(drv3));
    if (drv3 !== v) conclude;
  endtask : wait_drv

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    acc(0, 8'h00, 32'h0);
    chk("cfg3", 32'h00000100, rdata);
    acc(0, 8'h04, 32'h0);
    chk("delay3", 32'h0, rdata);
    acc(0, 8'h08, 32'h0);
    chk("hold3", 32'h0, rdata);
    acc(0, 8'h24, 32'h0);
    chk("unmapped error", 32'h1, 32'(slverr));
    $display("reset test done");
  endtask : t_reset

  task automatic t_card;
    acc(1, 8'h10, 32'h00000002);
    acc(0, 8'h10, 32'h0);
    chk("cfg4 absent", 32'h0, rdata);
    chk("relay4 absent", 32'h0, 32'(drv4));
    chk("relay4 contact", 32'h0, 32'(cl4));
    card4 <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1, 8'h10, 32'h00000102);
    acc(0, 8'h10, 32'h0);
    chk("cfg4 present", 32'h00000102, rdata);
    acc(0, 8'h20, 32'h0);
    chk("status", 32'h00000003, rdata);
    $display("card test done");
  endtask : t_card

  task automatic t_timing;
    int s;
    acc(1, 8'h00, 32'h00000102);
    acc(1, 8'h04, 32'h3);
    acc(1, 8'h08, 32'h2);
    s = sw3;
    cond[2] <= 1'b1;
    repeat (10) @(posedge clk);
    cond[2] <= 1'b0;
    repeat (5) @(posedge clk);
    cond[2] <= 1'b1;
    repeat (27) @(posedge clk);
    chk("early drive", 32'h0, 32'(drv3));
    wait_drv(1'b1, 20);
    cond[2] <= 1'b0;
    repeat (17) @(posedge clk);
    chk("held drive", 32'h1, 32'(drv3));
    chk("relay3 contact", 32'h1, 32'(cl3));
    wait_drv(1'b0, 20);
    repeat (2) @(posedge clk);
    chk("switch count", 32'(s + 2), 32'(sw3));
    acc(1, 8'h04, 32'h0000ffff);
    acc(0, 8'h04, 32'h0);
    chk("delay clamp", 32'h0000270f, rdata);
    $display("timing test done");
  endtask : t_timing

  task automatic t_polarity;
    acc(1, 8'h04, 32'h0);
    acc(1, 8'h00, 32'h00000002);
    wait_drv(1'b1, 4);
    cond[2] <= 1'b1;
    wait_drv(1'b0, 4);
    cond[2] <= 1'b0;
    $display("polarity test done");
  endtask : t_polarity

  task automatic t_locks;
    logic [3:0] codes [5];
    logic [4:0] pol_lock;
    int k;
    codes = '{4'h1, 4'h9, 4'ha, 4'hb, 4'he};
    pol_lock = 5'b10111;
    for (k = 0; k < 5; k++) begin
      acc(1, 8'h00, 32'h00000002);
      acc(1, 8'h0c, 32'(codes[k]));
      acc(1, 8'h04, 32'h5);
      acc(1, 8'h08, 32'h5);
      acc(0, 8'h04, 32'h0);
      chk("locked delay", 32'h0, rdata);
      acc(0, 8'h08, 32'h0);
      chk("locked hold", 32'h0, rdata);
      if (pol_lock[k]) begin
        acc(0, 8'h00, 32'h0);
        chk("locked polarity", 32'h1, 32'(rdata[8]));
        cond[codes[k]] <= 1'b1;
        wait_drv(1'b1, 3);
        cond[codes[k]] <= 1'b0;
        wait_drv(1'b0, 3);
      end
    end
    acc(1, 8'h00, 32'h00000102);
    acc(1, 8'h00, 32'h00000109);
    acc(0, 8'h00, 32'h0);
    chk("app source at cfg", 32'h2, 32'(rdata[3:0]));
    $display("lock test done");
  endtask : t_locks

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cond = '0;
    card3 = 1'b1;
    card4 = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_card;
    t_timing;
    t_polarity;
    t_locks;
    conclude;
  end
endmodule : tb_top
